// >>> rtl/ebt_defs.svh
// offsets, field positions, reset values and timing counts of the eight-bit timer
`ifndef EBT_DEFS_SVH
`define EBT_DEFS_SVH

// register addresses on the cpu register port
`define EBT_ADDR_CONTROL 8'hd2
`define EBT_ADDR_COUNT 8'hd0
`define EBT_ADDR_REFERENCE 8'hd1
`define EBT_ADDR_PORT3_CONFIG 8'hef

// reset values
`define EBT_CONTROL_RESET 8'h00
`define EBT_REFERENCE_RESET 8'hff
`define EBT_COUNT_RESET 8'h00

// control register field positions
`define EBT_BIT_PENDING 0
`define EBT_BIT_MATCH_EN 1
`define EBT_BIT_OVF_EN 2
`define EBT_BIT_CLEAR 3
`define EBT_MODE_LSB 4
`define EBT_MODE_MSB 5
`define EBT_CLK_LSB 6
`define EBT_CLK_MSB 7

// port 3 configuration: capture source select
`define EBT_BIT_P3_CAPTURE 2

// interrupt vectors of level 0
`define EBT_VECTOR_OVF 8'hfa
`define EBT_VECTOR_MATCH 8'hfc

// counter extremes
`define EBT_COUNT_MAX 8'hff

// oscillator and prescaler divide ratios
`define EBT_OSC_FREQ_HZ 20000000
`define EBT_DIV_SLOW 4096
`define EBT_DIV_MID 256
`define EBT_DIV_FAST 8
`define EBT_PRESCALE_WIDTH 12

`endif

// >>> rtl/ebt_edge_sync.sv
// two-flop synchroniser with edge detection for a pin input
`timescale 1ns/100ps
module ebt_edge_sync (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // asynchronous pin
    input wire logic pin_async,
    // synchronised results
    output logic rise_pulse,
    output logic fall_pulse
);
    logic meta_reg;
    logic meta_next;
    logic sync_reg;
    logic sync_next;
    logic prev_reg;
    logic prev_next;

    // next values of the synchroniser chain
    always_comb begin
        meta_next = pin_async;
        sync_next = meta_reg;
        prev_next = sync_reg;
    end

    // register the chain
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            prev_reg <= prev_next;
        end
    end

    // edges seen only after the second flop
    assign rise_pulse = sync_reg & ~prev_reg;
    assign fall_pulse = ~sync_reg & prev_reg;
endmodule

// >>> rtl/ebt_pkg.sv
// types shared by the eight-bit timer files
package ebt_pkg;

    typedef logic [7:0] ebt_byte_type;

    // operating mode held in the control register
    typedef enum logic [1:0] {
        ebt_mode_interval = 2'h0,
        ebt_mode_capture_rise = 2'h1,
        ebt_mode_capture_fall = 2'h2,
        ebt_mode_pwm = 2'h3
    } ebt_mode_type;

    // timer input clock selection
    typedef enum logic [1:0] {
        ebt_clk_div_slow = 2'h0,
        ebt_clk_div_mid = 2'h1,
        ebt_clk_div_fast = 2'h2,
        ebt_clk_external = 2'h3
    } ebt_clk_sel_type;

endpackage

// >>> rtl/ebt_timer.sv
// eight-bit timer with interval, pwm and capture modes
`timescale 1ns/100ps
`include "ebt_defs.svh"
module ebt_timer (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // cpu register port
    input wire ebt_pkg::ebt_byte_type reg_addr,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire ebt_pkg::ebt_byte_type reg_wdata,
    output ebt_pkg::ebt_byte_type reg_rdata,
    // interrupt level 0
    output logic level0_request,
    output ebt_pkg::ebt_byte_type irq_vector,
    input wire logic ovf_ack,
    // pins
    input wire logic ext_clock_pin,
    input wire logic capture_in_pin,
    output logic pwm_out_pin
);
    import ebt_pkg::*;

    // address match for a write or read strobe
    function automatic logic addr_hit(input ebt_byte_type addr, input ebt_byte_type target);
        addr_hit = (addr == target);
    endfunction

    // prescaler tap: true on the last cycle of each divide period
    function automatic logic div_tap(input logic [`EBT_PRESCALE_WIDTH-1:0] pre,
                                     input logic [`EBT_PRESCALE_WIDTH-1:0] mask);
        div_tap = ((pre & mask) == mask);
    endfunction

    localparam logic [`EBT_PRESCALE_WIDTH-1:0] mask_slow = `EBT_PRESCALE_WIDTH'(`EBT_DIV_SLOW - 1);
    localparam logic [`EBT_PRESCALE_WIDTH-1:0] mask_mid = `EBT_PRESCALE_WIDTH'(`EBT_DIV_MID - 1);
    localparam logic [`EBT_PRESCALE_WIDTH-1:0] mask_fast = `EBT_PRESCALE_WIDTH'(`EBT_DIV_FAST - 1);

    logic [`EBT_PRESCALE_WIDTH-1:0] prescale_reg;
    logic [`EBT_PRESCALE_WIDTH-1:0] prescale_next;
    ebt_byte_type control_reg;
    ebt_byte_type control_next;
    ebt_byte_type count_reg;
    ebt_byte_type count_next;
    ebt_byte_type reference_reg;
    ebt_byte_type reference_next;
    logic capture_sel_reg;
    logic capture_sel_next;
    logic toggle_reg;
    logic toggle_next;
    logic ovf_pend_reg;
    logic ovf_pend_next;
    logic pwm_out_next;
    logic request_next;
    ebt_byte_type vector_next;
    ebt_byte_type rdata_next;
    logic level0_request_reg;
    ebt_byte_type irq_vector_reg;
    ebt_byte_type reg_rdata_reg;
    logic pwm_out_reg;

    logic ext_rise;
    logic cap_rise;
    logic cap_fall;
    logic timer_tick;
    logic wr_control;
    logic wr_reference;
    logic wr_port3;
    logic capture_edge;
    logic match_event;
    logic capture_event;
    logic ovf_event;
    ebt_mode_type mode;
    ebt_clk_sel_type clk_sel;

    // external clock pin synchroniser
    ebt_edge_sync u_ext_clock_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .pin_async(ext_clock_pin),
        .rise_pulse(ext_rise),
        .fall_pulse()
    );

    // capture pin synchroniser
    ebt_edge_sync u_capture_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .pin_async(capture_in_pin),
        .rise_pulse(cap_rise),
        .fall_pulse(cap_fall)
    );

    // field decode and write strobes
    assign mode = ebt_mode_type'(control_reg[`EBT_MODE_MSB:`EBT_MODE_LSB]);
    assign clk_sel = ebt_clk_sel_type'(control_reg[`EBT_CLK_MSB:`EBT_CLK_LSB]);
    assign wr_control = reg_wr_en & addr_hit(reg_addr, `EBT_ADDR_CONTROL);
    assign wr_reference = reg_wr_en & addr_hit(reg_addr, `EBT_ADDR_REFERENCE);
    assign wr_port3 = reg_wr_en & addr_hit(reg_addr, `EBT_ADDR_PORT3_CONFIG);

    // prescaler free-runs on the oscillator clock
    always_comb begin
        prescale_next = prescale_reg + `EBT_PRESCALE_WIDTH'(1);
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            prescale_reg <= '0;
        end else begin
            prescale_reg <= prescale_next;
        end
    end

    // input clock multiplexer
    always_comb begin
        case (clk_sel)
            ebt_clk_div_slow: timer_tick = div_tap(prescale_reg, mask_slow);
            ebt_clk_div_mid: timer_tick = div_tap(prescale_reg, mask_mid);
            ebt_clk_div_fast: timer_tick = div_tap(prescale_reg, mask_fast);
            ebt_clk_external: timer_tick = ext_rise;
            default: timer_tick = 1'b0;
        endcase
    end

    // capture edge, gated by the port3 source select
    always_comb begin
        capture_edge = 1'b0;
        if (capture_sel_reg) begin
            if (mode == ebt_mode_capture_rise) begin
                capture_edge = cap_rise;
            end else if (mode == ebt_mode_capture_fall) begin
                capture_edge = cap_fall;
            end
        end
    end

    // counter, reference and timer output next values
    always_comb begin
        count_next = count_reg;
        reference_next = reference_reg;
        toggle_next = toggle_reg;
        match_event = 1'b0;
        ovf_event = 1'b0;
        capture_event = 1'b0;
        if (wr_control && reg_wdata[`EBT_BIT_CLEAR]) begin
            count_next = `EBT_COUNT_RESET;
        end else if (timer_tick) begin
            if (mode == ebt_mode_interval && count_reg == reference_reg) begin
                count_next = `EBT_COUNT_RESET;
                match_event = 1'b1;
                toggle_next = ~toggle_reg;
            end else begin
                count_next = count_reg + 8'h01;
                ovf_event = (count_reg == `EBT_COUNT_MAX);
                match_event = (mode == ebt_mode_pwm) && (count_reg == reference_reg);
            end
        end
        if (capture_edge) begin
            reference_next = count_reg;
            capture_event = 1'b1;
        end else if (wr_reference) begin
            reference_next = reg_wdata;
        end
        // pwm compare uses next values so the pin lines up with the count
        if (mode == ebt_mode_pwm) begin
            pwm_out_next = (reference_next > count_next);
        end else begin
            pwm_out_next = toggle_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            count_reg <= `EBT_COUNT_RESET;
            reference_reg <= `EBT_REFERENCE_RESET;
            toggle_reg <= 1'b0;
            pwm_out_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            reference_reg <= reference_next;
            toggle_reg <= toggle_next;
            pwm_out_reg <= pwm_out_next;
        end
    end

    // control register, pending flags and interrupt request
    always_comb begin
        control_next = control_reg;
        capture_sel_next = capture_sel_reg;
        ovf_pend_next = ovf_pend_reg;
        if (wr_control) begin
            control_next = reg_wdata;
            control_next[`EBT_BIT_CLEAR] = 1'b0;
            // writing zero clears pending, writing one leaves it
            control_next[`EBT_BIT_PENDING] = control_reg[`EBT_BIT_PENDING] & reg_wdata[`EBT_BIT_PENDING];
        end
        if (match_event || capture_event) begin
            control_next[`EBT_BIT_PENDING] = 1'b1;
        end
        if (wr_port3) begin
            capture_sel_next = reg_wdata[`EBT_BIT_P3_CAPTURE];
        end
        if (ovf_ack) begin
            ovf_pend_next = 1'b0;
        end
        if (ovf_event && control_reg[`EBT_BIT_OVF_EN]) begin
            ovf_pend_next = 1'b1;
        end
        // match request only while its enable is set
        request_next = ovf_pend_next |
                       (control_next[`EBT_BIT_PENDING] & control_next[`EBT_BIT_MATCH_EN]);
        if (ovf_pend_next) begin
            vector_next = `EBT_VECTOR_OVF;
        end else begin
            vector_next = `EBT_VECTOR_MATCH;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            control_reg <= `EBT_CONTROL_RESET;
            capture_sel_reg <= 1'b0;
            ovf_pend_reg <= 1'b0;
            level0_request_reg <= 1'b0;
            irq_vector_reg <= `EBT_VECTOR_MATCH;
        end else begin
            control_reg <= control_next;
            capture_sel_reg <= capture_sel_next;
            ovf_pend_reg <= ovf_pend_next;
            level0_request_reg <= request_next;
            irq_vector_reg <= vector_next;
        end
    end

    // cpu read data, unmapped addresses read zero
    always_comb begin
        rdata_next = reg_rdata_reg;
        if (reg_rd_en) begin
            if (addr_hit(reg_addr, `EBT_ADDR_CONTROL)) begin
                rdata_next = control_reg;
            end else if (addr_hit(reg_addr, `EBT_ADDR_COUNT)) begin
                rdata_next = count_reg;
            end else if (addr_hit(reg_addr, `EBT_ADDR_REFERENCE)) begin
                rdata_next = reference_reg;
            end else if (addr_hit(reg_addr, `EBT_ADDR_PORT3_CONFIG)) begin
                rdata_next = '0;
                rdata_next[`EBT_BIT_P3_CAPTURE] = capture_sel_reg;
            end else begin
                rdata_next = '0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            reg_rdata_reg <= '0;
        end else begin
            reg_rdata_reg <= rdata_next;
        end
    end

    // outputs straight from flops
    assign reg_rdata = reg_rdata_reg;
    assign level0_request = level0_request_reg;
    assign irq_vector = irq_vector_reg;
    assign pwm_out_pin = pwm_out_reg;
endmodule

// >>> tb/ebt_chk.sv
// port checker for the eight-bit timer
`timescale 1ns/100ps
module ebt_chk (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // cpu register port
    input wire ebt_pkg::ebt_byte_type reg_addr,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire ebt_pkg::ebt_byte_type reg_wdata,
    input wire ebt_pkg::ebt_byte_type reg_rdata,
    // interrupt and pins
    input wire logic level0_request,
    input wire ebt_pkg::ebt_byte_type irq_vector,
    input wire logic ovf_ack,
    input wire logic ext_clock_pin,
    input wire logic capture_in_pin,
    input wire logic pwm_out_pin
);
    import ebt_pkg::*;
    ebt_byte_type sh_reg;
    ebt_byte_type sh_next;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // shadow of written control, clear and pending bits dropped
    always_comb begin
        sh_next = sh_reg;
        if (reg_wr_en && reg_addr == 8'hd2) sh_next = reg_wdata & 8'hf6;
    end
    always_ff @(posedge ref_clk) begin
        if (reset) sh_reg <= 8'h00;
        else sh_reg <= sh_next;
    end
    chk_reset_quiet: assert property (disable iff (1'b0)
        reset |=> !level0_request && irq_vector == 8'hfc && !pwm_out_pin) else $error("not quiet after reset");
    chk_ctrl_read: assert property (reg_rd_en && reg_addr == 8'hd2
        |=> (reg_rdata & 8'hfe) == $past(sh_reg)) else $error("control read back wrong");
    chk_ovf_vec: assert property (irq_vector == 8'hfa |-> level0_request)
        else $error("overflow vector without request");
    chk_ovf_ack: assert property (ovf_ack && irq_vector == 8'hfa && !sh_reg[1] |=> !level0_request)
        else $error("overflow request kept after service");
    chk_match_gate: assert property (level0_request && irq_vector == 8'hfc |-> sh_reg[1])
        else $error("match request while disabled");
    chk_ovf_enable: assert property ($rose(irq_vector == 8'hfa) |-> sh_reg[2])
        else $error("overflow pending while disabled");
    // pin change follows the mode one cycle back, so interval must hold for two
    chk_toggle_match: assert property ($changed(pwm_out_pin) && $past(sh_reg[5:4]) == 2'h0
        && $past(sh_reg[5:4], 2) == 2'h0 && sh_reg[1] |-> level0_request) else $error("toggle without match request");
    // a reference write may raise the pin anywhere in a tick
    chk_pwm_width: assert property ($rose(pwm_out_pin) && sh_reg[7:4] == 4'hb && !$past(reg_wr_en)
        |=> pwm_out_pin [*7]) else $error("pwm high shorter than one tick");
    // main scenarios reached
    cov_toggle: cover property ($changed(pwm_out_pin) && sh_reg[5:4] == 2'h0);
    cov_ovf: cover property (ovf_ack && irq_vector == 8'hfa);
    cov_capture: cover property (level0_request && sh_reg[5:4] == 2'h1);
endmodule
bind ebt_timer ebt_chk u_chk (
    .ref_clk(ref_clk),
    .reset(reset),
    .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .level0_request(level0_request),
    .irq_vector(irq_vector),
    .ovf_ack(ovf_ack),
    .ext_clock_pin(ext_clock_pin),
    .capture_in_pin(capture_in_pin),
    .pwm_out_pin(pwm_out_pin)
);

// >>> tb/ebt_pulse_src.sv
// external clock and capture pulse source
`timescale 1ns/100ps
module ebt_pulse_src (
    // reference clock
    input wire logic ref_clk,
    // pins toward the timer
    output logic ext_clock_pin,
    output logic capture_in_pin
);
    // both pins idle low
    initial begin
        ext_clock_pin = 1'b0;
        capture_in_pin = 1'b0;
    end
    // slow pulses, levels held past the synchroniser
    task automatic clk_pulses(input int n);
        repeat (n) begin
            repeat (4) @(posedge ref_clk);
            ext_clock_pin <= 1'b1;
            repeat (4) @(posedge ref_clk);
            ext_clock_pin <= 1'b0;
        end
    endtask
    // move the capture pin, then let it settle
    task automatic cap_level(input logic v);
        repeat (4) @(posedge ref_clk);
        capture_in_pin <= v;
        repeat (8) @(posedge ref_clk);
    endtask
endmodule

// >>> tb/tb_eight_bit_timer_interval_pwm_capture.sv
// self-checking bench for the eight-bit timer
`timescale 1ns/100ps
module tb_eight_bit_timer_interval_pwm_capture;
    import ebt_pkg::*;
    logic ref_clk = 1'b0;
    logic reset;
    ebt_byte_type reg_addr;
    ebt_byte_type reg_wdata;
    logic reg_wr_en;
    logic reg_rd_en;
    logic ovf_ack;
    ebt_byte_type reg_rdata;
    ebt_byte_type irq_vector;
    logic level0_request;
    logic pwm_out_pin;
    logic ext_clock_pin;
    logic capture_in_pin;
    logic rd_d = 1'b0;
    logic [15:0] exp_q[$];
    logic [15:0] note;
    int err_total = 0;
    int samples_checked = 0;
    int seed = 54556;
    int n;
    int m;
    int divs[3] = '{4096, 256, 8};
    ebt_byte_type r;
    always #25 ref_clk = ~ref_clk;
    ebt_timer dut (
        .ref_clk(ref_clk),
        .reset(reset),
        .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .level0_request(level0_request),
        .irq_vector(irq_vector),
        .ovf_ack(ovf_ack),
        .ext_clock_pin(ext_clock_pin),
        .capture_in_pin(capture_in_pin),
        .pwm_out_pin(pwm_out_pin)
    );
    ebt_pulse_src src (
        .ref_clk(ref_clk),
        .ext_clock_pin(ext_clock_pin),
        .capture_in_pin(capture_in_pin)
    );
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wr(input ebt_byte_type a, input ebt_byte_type d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr_en <= 1'b1;
        @(posedge ref_clk);
        reg_wr_en <= 1'b0;
    endtask
    // read strobe, expected value and mask noted
    task automatic rd(input ebt_byte_type a, input ebt_byte_type e, input ebt_byte_type k);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        exp_q.push_back({e & k, k});
        @(posedge ref_clk);
        reg_rd_en <= 1'b0;
        @(posedge ref_clk);
    endtask
    // length of the k-th pin run from now, k of 1 is the run in progress
    task automatic seg(input int k, output int c);
        logic p;
        repeat (k) begin
            p = pwm_out_pin;
            c = 0;
            while (pwm_out_pin === p && c < 5000) begin
                @(posedge ref_clk);
                c++;
            end
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // read answers against the oldest note
    always @(posedge ref_clk) begin
        if (rd_d) begin
            note = exp_q.pop_front();
            chk("rdata", {8'h00, note[15:8]}, {8'h00, reg_rdata & note[7:0]});
        end
        rd_d <= reg_rd_en;
    end
    // hang guard
    initial begin
        repeat (60000) @(posedge ref_clk);
        err_total++;
        conclude();
    end
    initial begin
        reset <= 1'b1;
        reg_addr <= 8'h00;
        reg_wdata <= 8'h00;
        reg_wr_en <= 1'b0;
        reg_rd_en <= 1'b0;
        ovf_ack <= 1'b0;
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        rd(8'hd2, 8'h00, 8'hff);
        rd(8'hd1, 8'hff, 8'hff);
        rd(8'h55, 8'h00, 8'hff);
        // random control words, kept out of pwm mode
        repeat (3) begin
            r = 8'($random(seed)) & 8'hdf;
            wr(8'hd2, r);
            rd(8'hd2, r & 8'hf6, 8'hfe);
        end
        wr(8'hd1, 8'h00);
        // counter cleared so every tick matches the zero reference
        for (int i = 0; i < 3; i++) begin
            wr(8'hd2, {i[1:0], 6'h08});
            repeat (2) @(posedge ref_clk);
            seg(2, n);
            chk("toggle gap", 16'(divs[i]), 16'(n));
        end
        wr(8'hd1, 8'h02);
        wr(8'hd2, 8'h82);
        seg(2, n);
        chk("match gap", 16'd24, 16'(n));
        rd(8'hd2, 8'h83, 8'hff);
        chk("request", 16'h01fc, {7'h00, level0_request, irq_vector});
        wr(8'hd2, 8'h82);
        rd(8'hd2, 8'h82, 8'hff);
        wr(8'hd2, 8'h80);
        seg(2, n);
        chk("gated", 16'd0, 16'(level0_request));
        rd(8'hd2, 8'h81, 8'hff);
        wr(8'hd1, 8'hff);
        repeat (40) @(posedge ref_clk);
        wr(8'hd2, 8'h88);
        rd(8'hd0, 8'h00, 8'hfe);
        wr(8'hd1, 8'h00);
        wr(8'hd2, 8'hb0);
        repeat (10) @(posedge ref_clk);
        n = 0;
        repeat (2100) begin
            @(posedge ref_clk);
            n += (pwm_out_pin !== 1'b0);
        end
        chk("pwm zero", 16'd0, 16'(n));
        // skip the run cut by the reference write and the run after it, then two adjacent runs
        wr(8'hd1, 8'h40);
        seg(2, n);
        seg(1, n);
        seg(1, m);
        chk("pwm high", 16'd512, 16'(pwm_out_pin ? n : m));
        chk("pwm period", 16'd2048, 16'(n + m));
        wr(8'hd2, 8'hb4);
        n = 0;
        while (irq_vector !== 8'hfa && n < 2100) begin
            @(posedge ref_clk);
            n++;
        end
        chk("ovf vector", 16'h01fa, {7'h00, level0_request, irq_vector});
        @(posedge ref_clk);
        ovf_ack <= 1'b1;
        @(posedge ref_clk);
        ovf_ack <= 1'b0;
        @(posedge ref_clk);
        chk("ovf cleared", 16'h00fc, {7'h00, level0_request, irq_vector});
        wr(8'hef, 8'h04);
        rd(8'hef, 8'h04, 8'hff);
        wr(8'hd2, 8'hda);
        src.clk_pulses(5);
        src.cap_level(1'b1);
        rd(8'hd1, 8'h05, 8'hff);
        rd(8'hd2, 8'hd3, 8'hff);
        wr(8'hd2, 8'he0);
        src.clk_pulses(3);
        src.cap_level(1'b0);
        rd(8'hd1, 8'h08, 8'hff);
        src.cap_level(1'b1);
        wr(8'hef, 8'h00);
        src.cap_level(1'b0);
        rd(8'hd1, 8'h08, 8'hff);
        conclude();
    end
endmodule
